// *** spi_eeprom_defs.vh ***
// Purpose: constants for the serial eeprom array read/write block
// Assumes: included by bare name from the design files
// Notes: opcodes are the usual serial eeprom instruction bytes
`ifndef SPI_EEPROM_DEFS_VH
`define SPI_EEPROM_DEFS_VH
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_ARRAY 8'h03
`define OP_WRITE_ARRAY 8'h02
`define ADDR_FIELD_BITS 16
`define ADDR_BITS_LARGE 11
`define PAGE_BYTES 32
`define PAGE_LSB_BITS 5
`define ERASED_BYTE 8'h00
`define DELIVERED_BYTE 8'hFF
`define CLK_PERIOD_NS 8
`define WRITE_CYCLE_TIME_NS 5000000
`define WRITE_CYCLE_CYCLES ((`WRITE_CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** byte_buffer2.v ***
// Purpose: two-entry valid/ready buffer for bytes
// Assumes: same clock on both sides
// Notes: full and empty are honest; in_ready drops when both entries hold data
`timescale 1ns/1ps
module byte_buffer2 #(
  parameter WIDTH = 8
)(
  input wire I_CLK,
  input wire I_RST_B,
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready,
  input wire i_flush
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg rd_ptr_reg;
  reg wr_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;
  assign o_in_ready = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always @(posedge I_CLK)
  begin
    if (!I_RST_B || i_flush)
    begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 2'h1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
  always @(posedge I_CLK)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end
endmodule // byte_buffer2

// *** spi_eeprom_array.v ***
// Purpose: array read and page write of a small spi eeprom, device side
// Assumes: spi mode 0/3, select and clock oversampled by I_CLK (at least 8x)
// Notes: status bits other than the write enable latch and the busy flag come in as plain ports
`timescale 1ns/1ps
`include "spi_eeprom_defs.vh"
module spi_eeprom_array #(
  parameter ADDR_BITS = `ADDR_BITS_LARGE,
  parameter WRITE_CYCLES = `WRITE_CYCLE_CYCLES
)(
  input wire I_CLK,
  input wire I_RST_B,
  input wire I_SPI_SEL_B,
  input wire I_SPI_SCK,
  input wire I_SPI_MOSI,
  output reg O_SPI_MISO,
  output reg O_SPI_MISO_OE,
  input wire I_BLOCK_PROTECT_HI,
  input wire I_BLOCK_PROTECT_LO,
  output reg O_WRITE_BUSY_FLAG,
  output reg O_WRITE_ENABLE_LATCH
);
  localparam DEPTH = 1 << ADDR_BITS;
  localparam PB = `PAGE_LSB_BITS;
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ERASE = 3'h1;
  localparam [2:0] ST_PROGRAM = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;
  reg [2:0] sel_sync_reg;
  reg [2:0] sck_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [1:0] bp_sync0_reg;
  reg [1:0] bp_sync1_reg;
  reg [7:0] mem_reg [0:DEPTH-1];
  reg [7:0] page_reg [0:`PAGE_BYTES-1];
  reg [`PAGE_BYTES-1:0] page_mark_reg;
  reg [ADDR_BITS-1:0] page_base_reg;
  reg [7:0] op_reg;
  reg [7:0] shift_in_reg;
  reg [2:0] bit_cnt_reg;
  reg [2:0] byte_cnt_reg;
  reg [ADDR_BITS-1:0] addr_reg;
  reg [7:0] shift_out_reg;
  reg reading_reg;
  reg write_armed_reg;
  reg write_data_seen_reg;
  reg [2:0] state_reg;
  reg [31:0] timer_reg;
  reg [PB:0] prog_idx_reg;
  reg [PB-1:0] page_off_reg;
  wire sel_active;
  wire sck_rise;
  wire sck_fall;
  wire sel_rise;
  wire [7:0] byte_in;
  wire byte_done;
  wire busy;
  wire page_protected;
  wire [1:0] bp;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  wire buf_pop;
  wire [PB-1:0] prog_off;
  // 2-stage sync then edge detect on stage 2/3 only
  always @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      sel_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      mosi_sync_reg <= 2'h0;
      bp_sync0_reg <= 2'h0;
      bp_sync1_reg <= 2'h0;
    end
    else
    begin
      sel_sync_reg <= {sel_sync_reg[1:0], I_SPI_SEL_B};
      sck_sync_reg <= {sck_sync_reg[1:0], I_SPI_SCK};
      mosi_sync_reg <= {mosi_sync_reg[0], I_SPI_MOSI};
      bp_sync0_reg <= {I_BLOCK_PROTECT_HI, I_BLOCK_PROTECT_LO};
      bp_sync1_reg <= bp_sync0_reg;
    end
  end
  assign sel_active = !sel_sync_reg[1];
  assign sel_rise = sel_sync_reg[1] && !sel_sync_reg[2];
  assign sck_rise = sck_sync_reg[1] && !sck_sync_reg[2] && sel_active;
  assign sck_fall = !sck_sync_reg[1] && sck_sync_reg[2] && sel_active;
  assign byte_in = {shift_in_reg[6:0], mosi_sync_reg[1]};
  assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);
  assign busy = (state_reg != ST_IDLE);
  assign bp = bp_sync1_reg;
  // protected area: upper quarter, upper half, whole array
  assign page_protected = (bp == 2'h3) ||
    (bp == 2'h2 && addr_reg[ADDR_BITS-1]) ||
    (bp == 2'h1 && (&addr_reg[ADDR_BITS-1:ADDR_BITS-2]));
  assign prog_off = prog_idx_reg[PB-1:0];
  // incoming write bytes queue here so the page store never misses a byte
  assign buf_pop = buf_out_valid;
  byte_buffer2 #(
    .WIDTH(8)
  ) u_wbuf (
    .I_CLK(I_CLK),
    .I_RST_B(I_RST_B),
    .i_in_valid(byte_done && write_armed_reg && byte_cnt_reg == 3'h3),
    .i_in_data(byte_in),
    .o_in_ready(buf_in_ready),
    .o_out_valid(buf_out_valid),
    .o_out_data(buf_out_data),
    .i_out_ready(buf_pop),
    .i_flush(!sel_active && !buf_out_valid)
  );
  // serial input framing
  always @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      op_reg <= 8'h00;
      shift_in_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      addr_reg <= {ADDR_BITS{1'b0}};
      reading_reg <= 1'b0;
      write_armed_reg <= 1'b0;
      write_data_seen_reg <= 1'b0;
      O_WRITE_ENABLE_LATCH <= 1'b0;
      page_base_reg <= {ADDR_BITS{1'b0}};
    end
    else if (!sel_active)
    begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      reading_reg <= 1'b0;
      write_armed_reg <= 1'b0;
      write_data_seen_reg <= 1'b0;
    end
    else if (sck_rise)
    begin
      shift_in_reg <= byte_in;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done)
      begin
        if (byte_cnt_reg != 3'h3)
        begin
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
        if (byte_cnt_reg == 3'h0)
        begin
          op_reg <= byte_in;
          if (byte_in == `OP_WRITE_ENABLE && !busy)
          begin
            O_WRITE_ENABLE_LATCH <= 1'b1;
          end
          if (byte_in == `OP_WRITE_DISABLE && !busy)
          begin
            O_WRITE_ENABLE_LATCH <= 1'b0;
          end
        end
        else if (byte_cnt_reg == 3'h1)
        begin
          // upper field bits dropped by the part-select
          addr_reg[ADDR_BITS-1:8] <= byte_in[ADDR_BITS-9:0];
        end
        else if (byte_cnt_reg == 3'h2)
        begin
          addr_reg[7:0] <= byte_in;
          if (op_reg == `OP_READ_ARRAY && !busy)
          begin
            reading_reg <= 1'b1;
          end
          if (op_reg == `OP_WRITE_ARRAY)
          begin
            page_base_reg <= {addr_reg[ADDR_BITS-1:8], byte_in};
            write_armed_reg <= O_WRITE_ENABLE_LATCH && !busy;
          end
        end
        else if (reading_reg)
        begin
          addr_reg <= addr_reg + {{(ADDR_BITS-1){1'b0}}, 1'b1};
        end
        else if (write_armed_reg)
        begin
          write_data_seen_reg <= 1'b1;
          addr_reg[PB-1:0] <= addr_reg[PB-1:0] + {{(PB-1){1'b0}}, 1'b1};
        end
      end
    end
    if (I_RST_B && state_reg == ST_WAIT && timer_reg == 32'h0)
    begin
      O_WRITE_ENABLE_LATCH <= 1'b0; // drops at cycle end even while a poll frame is open
    end
  end
  // page collector: offset wraps inside the page, later byte overwrites
  always @(posedge I_CLK)
  begin
    if (!I_RST_B || (sel_active && byte_cnt_reg == 3'h0 && !busy))
    begin
      page_mark_reg <= {`PAGE_BYTES{1'b0}};
    end
    else if (buf_pop)
    begin
      page_mark_reg[page_off_reg] <= 1'b1;
    end
  end
  always @(posedge I_CLK)
  begin
    if (byte_done && byte_cnt_reg == 3'h2)
    begin
      page_off_reg <= byte_in[PB-1:0];
    end
    else if (buf_pop)
    begin
      page_off_reg <= page_off_reg + {{(PB-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge I_CLK)
  begin
    if (buf_pop)
    begin
      page_reg[page_off_reg] <= buf_out_data;
    end
  end
  // self-timed cycle: erase marked bytes, program them, then wait tW
  always @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h0;
      prog_idx_reg <= {(PB+1){1'b0}};
      O_WRITE_BUSY_FLAG <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // bit count not a multiple of 8 or no data byte means no write
          if (sel_rise && write_data_seen_reg && bit_cnt_reg == 3'h0 && !page_protected)
          begin
            state_reg <= ST_ERASE;
            prog_idx_reg <= {(PB+1){1'b0}};
            O_WRITE_BUSY_FLAG <= 1'b1;
          end
        end
        ST_ERASE:
        begin
          if (!buf_out_valid)
          begin
            if (prog_idx_reg[PB])
            begin
              state_reg <= ST_PROGRAM;
              prog_idx_reg <= {(PB+1){1'b0}};
            end
            else
            begin
              prog_idx_reg <= prog_idx_reg + {{PB{1'b0}}, 1'b1};
            end
          end
        end
        ST_PROGRAM:
        begin
          if (prog_idx_reg[PB])
          begin
            state_reg <= ST_WAIT;
            timer_reg <= WRITE_CYCLES;
          end
          else
          begin
            prog_idx_reg <= prog_idx_reg + {{PB{1'b0}}, 1'b1};
          end
        end
        ST_WAIT:
        begin
          if (timer_reg == 32'h0)
          begin
            state_reg <= ST_IDLE;
            O_WRITE_BUSY_FLAG <= 1'b0;
          end
          else
          begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // array storage
  integer k;
  initial
  begin
    for (k = 0; k < DEPTH; k = k + 1)
    begin
      mem_reg[k] = `DELIVERED_BYTE;
    end
  end
  always @(posedge I_CLK)
  begin
    if (page_mark_reg[prog_off] && !prog_idx_reg[PB])
    begin
      if (state_reg == ST_ERASE && !buf_out_valid)
      begin
        mem_reg[{page_base_reg[ADDR_BITS-1:PB], prog_off}] <= `ERASED_BYTE;
      end
      else if (state_reg == ST_PROGRAM)
      begin
        mem_reg[{page_base_reg[ADDR_BITS-1:PB], prog_off}] <= page_reg[prog_off];
      end
    end
  end
  // serial output: load at byte start, shift after falling edges
  always @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      shift_out_reg <= 8'h00;
      O_SPI_MISO <= 1'b0;
      O_SPI_MISO_OE <= 1'b0;
    end
    else if (!sel_active || !reading_reg)
    begin
      O_SPI_MISO_OE <= 1'b0;
      O_SPI_MISO <= 1'b0;
      shift_out_reg <= mem_reg[addr_reg];
    end
    else if (sck_fall)
    begin
      O_SPI_MISO_OE <= 1'b1;
      if (bit_cnt_reg == 3'h0)
      begin
        O_SPI_MISO <= mem_reg[addr_reg][7];
        shift_out_reg <= {mem_reg[addr_reg][6:0], 1'b0};
      end
      else
      begin
        O_SPI_MISO <= shift_out_reg[7];
        shift_out_reg <= {shift_out_reg[6:0], 1'b0};
      end
    end
  end
endmodule // spi_eeprom_array

// *** spi_eeprom_array_assertions.sv ***
// Purpose: port-level checks of the eeprom array block
// Assumes: top module ports only, one clock domain
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module spi_eeprom_array_checker #(
  parameter ADDR_BITS = 11,
  parameter WRITE_CYCLES = 20
)(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_SPI_SEL_B,
  input wire logic I_SPI_SCK,
  input wire logic I_SPI_MOSI,
  input wire logic O_SPI_MISO,
  input wire logic O_SPI_MISO_OE,
  input wire logic I_BLOCK_PROTECT_HI,
  input wire logic I_BLOCK_PROTECT_LO,
  input wire logic O_WRITE_BUSY_FLAG,
  input wire logic O_WRITE_ENABLE_LATCH
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  property p_oe_needs_sel;
    $rose(O_SPI_MISO_OE) |-> !I_SPI_SEL_B;
  endproperty
  a_oe_needs_sel: assert property (p_oe_needs_sel) else $error("oe rose while deselected");
  property p_oe_released;
    I_SPI_SEL_B [*6] |-> !O_SPI_MISO_OE;
  endproperty
  a_oe_released: assert property (p_oe_released) else $error("oe held after deselect");
  property p_no_read_busy;
    O_WRITE_BUSY_FLAG && $past(O_WRITE_BUSY_FLAG, 4) |-> !O_SPI_MISO_OE;
  endproperty
  a_no_read_busy: assert property (p_no_read_busy) else $error("data out during write");
  property p_busy_on_deselect;
    $rose(O_WRITE_BUSY_FLAG) |-> I_SPI_SEL_B;
  endproperty
  a_busy_on_deselect: assert property (p_busy_on_deselect) else $error("busy while selected");
  property p_busy_needs_latch;
    $rose(O_WRITE_BUSY_FLAG) |-> $past(O_WRITE_ENABLE_LATCH);
  endproperty
  a_busy_needs_latch: assert property (p_busy_needs_latch) else $error("write without latch");
  property p_busy_not_protected;
    $rose(O_WRITE_BUSY_FLAG) |-> !($past(I_BLOCK_PROTECT_HI, 8) && $past(I_BLOCK_PROTECT_LO, 8));
  endproperty
  a_busy_not_protected: assert property (p_busy_not_protected) else $error("protected write");
  property p_busy_holds;
    $rose(O_WRITE_BUSY_FLAG) |=> O_WRITE_BUSY_FLAG [*8];
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy too short");
  property p_out_on_fall;
    O_SPI_MISO_OE && $past(O_SPI_MISO_OE) && $changed(O_SPI_MISO) |-> !I_SPI_SCK;
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("data out moved with clock high");
endmodule // spi_eeprom_array_checker
bind spi_eeprom_array spi_eeprom_array_checker #(.ADDR_BITS(ADDR_BITS), .WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_SPI_SEL_B(I_SPI_SEL_B), .I_SPI_SCK(I_SPI_SCK),
  .I_SPI_MOSI(I_SPI_MOSI), .O_SPI_MISO(O_SPI_MISO), .O_SPI_MISO_OE(O_SPI_MISO_OE),
  .I_BLOCK_PROTECT_HI(I_BLOCK_PROTECT_HI), .I_BLOCK_PROTECT_LO(I_BLOCK_PROTECT_LO),
  .O_WRITE_BUSY_FLAG(O_WRITE_BUSY_FLAG), .O_WRITE_ENABLE_LATCH(O_WRITE_ENABLE_LATCH));

// *** spi_host_model.sv ***
// Purpose: spi host, mode 0, link clock 160 ns
// Assumes: clock stands low between frames
// Notes: undriven data out reads as the inverse of the last bit
`timescale 1ns/1ps
module spi_host_model (
  input wire logic i_miso,
  input wire logic i_miso_oe,
  output logic o_sel_b,
  output logic o_sck,
  output logic o_mosi
);
  logic last_bit;
  initial
  begin
    o_sel_b = 1'b1;
    o_sck = 1'b0;
    o_mosi = 1'b0;
    last_bit = 1'b0;
  end
  task automatic sel(input logic v);
    o_sel_b = v;
    #80;
  endtask
  // msb first, n bits; sampled on rising clock
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      o_mosi = tx[i];
      #80 o_sck = 1'b1;
      last_bit = i_miso_oe ? i_miso : ~last_bit;
      rx[i] = last_bit;
      #80 o_sck = 1'b0;
    end
  endtask
endmodule // spi_host_model

// *** tb_top.sv ***
// Purpose: self-checking bench for the eeprom array block
// Assumes: short write cycle parameter
// Notes: host frames come from the host model tasks
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic bp_hi = 1'b0;
  logic bp_lo = 1'b0;
  logic oe_seen;
  wire sel_b, sck, mosi, miso, miso_oe, busy, latch;
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] rxq[$];
  always #4 clk = ~clk;
  always @(posedge clk) if (miso_oe === 1'b1) oe_seen = 1'b1;
  // long enough for frames to land inside one write cycle
  spi_eeprom_array #(.ADDR_BITS(11), .WRITE_CYCLES(2000)) dut (
    .I_CLK(clk), .I_RST_B(rst_b), .I_SPI_SEL_B(sel_b), .I_SPI_SCK(sck), .I_SPI_MOSI(mosi),
    .O_SPI_MISO(miso), .O_SPI_MISO_OE(miso_oe), .I_BLOCK_PROTECT_HI(bp_hi),
    .I_BLOCK_PROTECT_LO(bp_lo), .O_WRITE_BUSY_FLAG(busy), .O_WRITE_ENABLE_LATCH(latch));
  spi_host_model host (.i_miso(miso), .i_miso_oe(miso_oe), .o_sel_b(sel_b), .o_sck(sck), .o_mosi(mosi));
  task automatic finish_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [7:0] q[$], input int nrd, input int tail);
    logic [7:0] r;
    rxq.delete();
    oe_seen = 1'b0;
    host.sel(1'b0);
    foreach (q[i]) host.xfer(q[i], 8, r);
    repeat (nrd)
    begin
      host.xfer(8'h00, 8, r);
      rxq.push_back(r);
    end
    if (tail > 0) host.xfer(8'h00, tail, r);
    host.sel(1'b1);
    #400;
  endtask
  task automatic wait_busy(input logic v);
    int n;
    for (n = 0; n < 3000 && busy !== v; n++) @(posedge clk) #1;
    if (busy !== v)
    begin
      fail_count++;
      $display("FAIL %0t busy wait", $time);
      finish_test();
    end
  endtask
  // pins move one step after the edge, like every other stimulus
  task automatic set_bp(input logic [1:0] v);
    @(posedge clk) #1;
    {bp_hi, bp_lo} = v;
  endtask
  task automatic t_first_read;
    frame('{8'h03, 8'hF7, 8'hFF}, 3, 0);
    foreach (rxq[i]) chk(rxq[i], 8'hFF);
    frame('{8'h03, 8'h00, 8'h1E}, 0, 4);
    chk({7'h00, oe_seen}, 8'h01);
    chk({7'h00, miso_oe}, 8'h00);
  endtask
  task automatic t_no_latch;
    frame('{8'h06}, 0, 0);
    chk({7'h00, latch}, 8'h01);
    frame('{8'h04}, 0, 0);
    chk({7'h00, latch}, 8'h00);
    frame('{8'h02, 8'h00, 8'h40, 8'h11}, 0, 0);
    chk({7'h00, busy}, 8'h00);
  endtask
  task automatic t_page_wrap;
    frame('{8'h06}, 0, 0);
    frame('{8'h02, 8'h00, 8'h1E, 8'hA5, 8'h5A, 8'hC3}, 0, 0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    frame('{8'h03, 8'h00, 8'h1E}, 3, 0);
    chk(rxq[0], 8'hA5);
    chk(rxq[1], 8'h5A);
    chk(rxq[2], 8'hFF);
    frame('{8'h03, 8'h00, 8'h00}, 1, 0);
    chk(rxq[0], 8'hC3);
    // top byte never written, so only a wrap brings C3 next
    frame('{8'h03, 8'hFF, 8'hFF}, 2, 0);
    chk(rxq[0], 8'hFF);
    chk(rxq[1], 8'hC3);
  endtask
  task automatic t_busy_refuse;
    frame('{8'h06}, 0, 0);
    frame('{8'h02, 8'h00, 8'h44, 8'h66}, 0, 0);
    wait_busy(1'b1);
    frame('{8'h03, 8'h00, 8'h44}, 1, 0);
    chk({7'h00, oe_seen}, 8'h00);
    frame('{8'h06}, 0, 0);
    frame('{8'h02, 8'h00, 8'h48, 8'h77}, 0, 0);
    wait_busy(1'b0);
    frame('{8'h03, 8'h00, 8'h44}, 5, 0);
    chk(rxq[0], 8'h66);
    chk(rxq[4], 8'hFF);
  endtask
  task automatic t_bad_end;
    frame('{8'h06}, 0, 0);
    frame('{8'h02, 8'h00, 8'h60, 8'h12}, 0, 3);
    chk({7'h00, busy}, 8'h00);
    set_bp(2'h3);
    frame('{8'h06}, 0, 0);
    frame('{8'h02, 8'h07, 8'hC0, 8'h34}, 0, 0);
    chk({7'h00, busy}, 8'h00);
    set_bp(2'h2);
    frame('{8'h02, 8'h05, 8'h00, 8'h56}, 0, 0);
    chk({7'h00, busy}, 8'h00);
    set_bp(2'h1);
    frame('{8'h02, 8'h05, 8'h00, 8'h78}, 0, 0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    set_bp(2'h0);
    frame('{8'h03, 8'h05, 8'h00}, 1, 0);
    chk(rxq[0], 8'h78);
    frame('{8'h03, 8'h00, 8'h60}, 1, 0);
    chk(rxq[0], 8'hFF);
    frame('{8'h03, 8'h07, 8'hC0}, 1, 0);
    chk(rxq[0], 8'hFF);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    t_first_read();
    t_no_latch();
    t_page_wrap();
    t_busy_refuse();
    t_bad_end();
    finish_test();
  end
endmodule // tb_top
